// ===== verilog/ccce_exec.v
// Execution unit for call, watchdog kick, register clear and invert.
// Assumes one instruction per valid cycle; file read data arrives
// combinationally for the index on the instruction word.
`timescale 1ns/1ps
`default_nettype none
`include "ccce_map.vh"
module ccce_exec
(
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire        instr_valid_in,
  input  wire [11:0] instr_in,
  input  wire [10:0] program_counter_in,
  input  wire [7:0]  status_in,
  input  wire [7:0]  file_rdata_in,
  input  wire        prescaler_to_wdt_in,
  output reg  [4:0]  file_addr_out,
  output reg  [7:0]  file_wdata_out,
  output reg         file_we_out,
  output reg  [7:0]  accum_out,
  output reg         accum_we_out,
  output reg  [7:0]  status_out,
  output reg         status_we_out,
  output reg  [10:0] program_counter_out,
  output reg         pc_load_out,
  output reg  [10:0] stack_push_data_out,
  output reg         stack_push_out,
  output reg         flush_out,
  output reg         busy_out,
  output reg         watchdog_counter_clr_out,
  output reg         prescaler_clr_out
);
  wire        is_call;
  wire        is_kick;
  wire        is_clr;
  wire        is_inv;
  wire [7:0]  inv_val;
  reg         second_r;

  ccce_decode u_dec
  (
    .instr_in    (instr_in),
    .is_call_out (is_call),
    .is_kick_out (is_kick),
    .is_clr_out  (is_clr),
    .is_inv_out  (is_inv)
  );

  assign inv_val = ~file_rdata_in;

  // Registered execution of each instruction
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      file_addr_out            <= 5'h00;
      file_wdata_out           <= 8'h00;
      file_we_out              <= 1'b0;
      accum_out                <= 8'h00;
      accum_we_out             <= 1'b0;
      status_out               <= 8'h00;
      status_we_out            <= 1'b0;
      program_counter_out      <= 11'h000;
      pc_load_out              <= 1'b0;
      stack_push_data_out      <= 11'h000;
      stack_push_out           <= 1'b0;
      flush_out                <= 1'b0;
      busy_out                 <= 1'b0;
      watchdog_counter_clr_out <= 1'b0;
      prescaler_clr_out        <= 1'b0;
      second_r                 <= 1'b0;
    end
    else
    begin
      file_we_out              <= 1'b0;
      accum_we_out             <= 1'b0;
      status_we_out            <= 1'b0;
      pc_load_out              <= 1'b0;
      stack_push_out           <= 1'b0;
      flush_out                <= 1'b0;
      watchdog_counter_clr_out <= 1'b0;
      prescaler_clr_out        <= 1'b0;
      busy_out                 <= 1'b0;
      second_r                 <= 1'b0;
      file_addr_out            <= instr_in[4:0];
      status_out               <= status_in;
      if (second_r)
      begin
        // Second call cycle discards the prefetched word
        flush_out <= 1'b1;
      end
      else if (instr_valid_in)
      begin
        if (is_call)
        begin
          stack_push_data_out <= program_counter_in + 11'h001;
          stack_push_out      <= 1'b1;
          program_counter_out <= {status_in[`CCCE_PAGE_HI:`CCCE_PAGE_LO],
                                  1'b0,
                                  instr_in[7:0]};
          pc_load_out         <= 1'b1;
          busy_out            <= 1'b1;
          second_r            <= 1'b1;
        end
        else if (is_kick)
        begin
          watchdog_counter_clr_out <= 1'b1;
          prescaler_clr_out        <= prescaler_to_wdt_in;
          status_out[`CCCE_TO_BIT] <= 1'b1;
          status_out[`CCCE_PD_BIT] <= 1'b1;
          status_we_out            <= 1'b1;
        end
        else if (is_clr)
        begin
          file_wdata_out          <= 8'h00;
          file_we_out             <= 1'b1;
          status_out[`CCCE_Z_BIT] <= 1'b1;
          status_we_out           <= 1'b1;
        end
        else if (is_inv)
        begin
          if (instr_in[`CCCE_DEST_BIT])
          begin
            file_wdata_out <= inv_val;
            file_we_out    <= 1'b1;
          end
          else
          begin
            accum_out    <= inv_val;
            accum_we_out <= 1'b1;
          end
          status_out[`CCCE_Z_BIT] <= (inv_val == 8'h00);
          status_we_out           <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== shared/ccce_map.vh
// Constants for the call / clear / complement execution block.
// Assumes a 12-bit instruction word and 11-bit program counter.
// Operation
// - Call loads the eight-bit literal into program counter bits 7 to 0.
// - Call fills program counter bits 10:9 from status bits 6:5.
// - Call always forces program counter bit 8 to zero.
// - Call is one word, two cycles; second cycle flushes the fetched instruction.
// - Call pushes program counter plus one onto the return stack first.
// - Watchdog kick, code 0x004, zeroes the watchdog counter in one cycle.
// - Watchdog kick clears the prescaler only when assigned to the watchdog.
// - Watchdog kick sets the time-out flag and power-down flag to one.
// - Register clear writes zero to the addressed register and sets zero flag.
// - Register invert produces the bitwise inverse of the register in one cycle.
// - Invert with destination bit 0 writes the accumulator, register unchanged.
// - Invert with destination bit 1 writes the result back to the register.
`ifndef CCCE_MAP_VH
`define CCCE_MAP_VH
`define CCCE_CALL_MASK   12'hf00
`define CCCE_CALL_CODE   12'h900
`define CCCE_KICK_CODE   12'h004
`define CCCE_CLR_MASK    12'hfe0
`define CCCE_CLR_CODE    12'h060
`define CCCE_INV_MASK    12'hfc0
`define CCCE_INV_CODE    12'h240
`define CCCE_DEST_BIT    5
`define CCCE_PAGE_HI     6
`define CCCE_PAGE_LO     5
`define CCCE_TO_BIT      4
`define CCCE_PD_BIT      3
`define CCCE_Z_BIT       2
`define CCCE_CALL_CYCLES 2
`endif

// ===== verilog/ccce_decode.v
// Instruction classifier for the call / clear / complement block.
// Assumes a registered, stable instruction word from the fetch stage.
`timescale 1ns/1ps
`default_nettype none
`include "ccce_map.vh"
module ccce_decode
(
  input  wire [11:0] instr_in,
  output wire        is_call_out,
  output wire        is_kick_out,
  output wire        is_clr_out,
  output wire        is_inv_out
);
  // Opcode matching against fixed patterns
  assign is_call_out = (instr_in & `CCCE_CALL_MASK) == `CCCE_CALL_CODE;
  assign is_kick_out = instr_in == `CCCE_KICK_CODE;
  assign is_clr_out  = (instr_in & `CCCE_CLR_MASK) == `CCCE_CLR_CODE;
  assign is_inv_out  = (instr_in & `CCCE_INV_MASK) == `CCCE_INV_CODE;
endmodule
`default_nettype wire

// ===== verif/ccce_exec_asserts.sv
// Assertions bound to ccce_exec.
// Sees the unit's ports only; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ccce_exec_asserts
(
  input wire logic clk_in, sys_rst_in, instr_valid_in, prescaler_to_wdt_in, busy_out,
  input wire logic file_we_out, accum_we_out, status_we_out, pc_load_out, flush_out,
  input wire logic stack_push_out, watchdog_counter_clr_out, prescaler_clr_out,
  input wire logic [11:0] instr_in,
  input wire logic [10:0] program_counter_in, program_counter_out, stack_push_data_out,
  input wire logic [7:0] status_in, file_rdata_in, file_wdata_out, accum_out, status_out
);
  // Decode of the instruction taken at this edge
  wire go = instr_valid_in && !busy_out;
  wire call = go && instr_in[11:8] == 4'h9;
  wire kick = go && instr_in == 12'h004;
  wire clr = go && instr_in[11:5] == 7'h03;
  wire inv = go && instr_in[11:6] == 6'h09;
  wire [7:0] res = file_we_out ? file_wdata_out : accum_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence call_s; call ##1 pc_load_out; endsequence
  // Answers come one cycle after the taking edge, the call flush two cycles after
  call_pc_a: assert property (call |=> program_counter_out ==
    {$past(status_in[6:5]), 1'b0, $past(instr_in[7:0])}) else $error("bad call target");
  call_push_a: assert property (call |=> stack_push_out &&
    stack_push_data_out == $past(program_counter_in) + 11'h1) else $error("bad push");
  call_flush_a: assert property (call_s |-> busy_out ##1 (flush_out && !pc_load_out))
    else $error("bad flush");
  kick_flags_a: assert property (kick |=> watchdog_counter_clr_out &&
    status_we_out && status_out[4:3] == 2'b11) else $error("bad kick");
  kick_presc_a: assert property (kick |=>
    prescaler_clr_out == $past(prescaler_to_wdt_in)) else $error("bad prescaler clear");
  clr_zero_a: assert property (clr |=> file_we_out && file_wdata_out == 8'h00 &&
    status_out[2]) else $error("bad clear");
  inv_dest_a: assert property (inv |=> file_we_out == $past(instr_in[5]) &&
    accum_we_out != $past(instr_in[5])) else $error("bad destination");
  inv_res_a: assert property (inv |=> res == ~$past(file_rdata_in) &&
    status_out[2] == (res == 8'h00)) else $error("bad invert");
endmodule
bind ccce_exec ccce_exec_asserts chk (.*);
`default_nettype wire

// ===== verif/tb.sv
// Random bench for ccce_exec with fixed seed.
// Drives all inputs itself; the checker is bound apart.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in = 0, sys_rst_in = 1, instr_valid_in = 0, prescaler_to_wdt_in = 0;
  logic [11:0] instr_in = 0;
  logic [10:0] program_counter_in = 0;
  logic [7:0] status_in = 0, file_rdata_in = 0;
  wire [4:0] file_addr_out;
  wire [7:0] file_wdata_out, accum_out, status_out;
  wire [10:0] program_counter_out, stack_push_data_out;
  wire file_we_out, accum_we_out, status_we_out, pc_load_out, stack_push_out, flush_out;
  wire busy_out, watchdog_counter_clr_out, prescaler_clr_out;
  int mismatches = 0, samples_checked = 0;
  logic [15:0] r;
  ccce_exec dut (.*);
  // Clock of 8 ns
  always #4 clk_in = ~clk_in;
  // Count and report one compare
  task chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) mismatches++;
    if (g !== e) $display("wrong value %s: expected %h, seen %h", n, e, g);
  endtask
  task tally_and_finish;
    $display("%0d checks, %0d mismatches", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One instruction; a call holds valid into its busy cycle, which must be ignored
  task run(input logic [11:0] op, input logic [7:0] rd);
    logic [15:0] v;
    v = $urandom;
    @(posedge clk_in);
    {instr_in, program_counter_in, status_in, file_rdata_in} <= {op, v[10:0], v[15:8], rd};
    {instr_valid_in, prescaler_to_wdt_in} <= {1'b1, v[11]};
    @(posedge clk_in);
    instr_valid_in <= op[11:8] == 4'h9;
    #1;
    if (op[11:8] == 4'h9)
    begin
      chk("call",
        {3'b111, v[14:13], 1'b0, op[7:0], v[10:0] + 11'h1},
        {pc_load_out, busy_out, stack_push_out, program_counter_out, stack_push_data_out});
      @(posedge clk_in);
      instr_valid_in <= 0;
      #1 chk("flush", 2'b10, {flush_out, pc_load_out});
    end
    else if (op[11:6] == 6'h09)
      chk("invert",
        {op[5], !op[5], ~rd, v[15:11], rd == 8'hff, v[9:8]},
        {file_we_out, accum_we_out, op[5] ? file_wdata_out : accum_out, status_out});
    else if (op == 12'h004)
      chk("kick",
        {2'b11, v[11], v[15:13], 2'b11, v[10:8]},
        {watchdog_counter_clr_out, status_we_out, prescaler_clr_out, status_out});
    else if (op[11:5] == 7'h03)
      chk("clear",
        {2'b11, 8'h00, v[15:11], 1'b1, v[9:8], op[4:0]},
        {file_we_out, status_we_out, file_wdata_out, status_out, file_addr_out});
    $display("test %h done", op);
  endtask
  // Reset, corner cases, then a random mix of all four operations
  initial
  begin
    void'($urandom(32'h0be7));
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 0;
    run(12'h9ff, 8'h00);
    run(12'h27f, 8'hff);
    for (int i = 0; i < 80; i++)
    begin
      r = $urandom;
      run(r[1:0] == 0 ? {4'h9, r[9:2]} : r[1:0] == 1 ? 12'h004 :
        r[1:0] == 2 ? {7'h03, r[6:2]} : {6'h09, r[7:2]}, i % 4 ? r[15:8] : 8'hff);
    end
    tally_and_finish;
  end
  // Cut a hang short
  initial
  begin
    #20000;
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
